// File: bbx_exec.sv
// execute unit for a subset of the byte, bit and branch instructions
//
// Overview of operation
// - add acc, file and carry, five flags
// - d zero to acc, one to file
// - a zero selects access bank
// - and literal into acc, n z
// - branch if negative: pc+2+2n
// - taken branch two cycles, else one
// - unconditional branch always, two cycles
// - skip next when tested bit zero
// - skip next when tested bit one
// - skip discards fetched word, adds nop
// - skipped two-word instruction costs three
`timescale 1ns/10ps
`include "bbx_regs.svh"
module bbx_exec #(
   parameter int MEM_DEPTH = 256
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic busy,
   output logic [20:0] pc_out
);
   // ========================================================================
   // parameter check
   if (MEM_DEPTH < 256 || MEM_DEPTH > 4096
         || (MEM_DEPTH & (MEM_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("bbx_exec: MEM_DEPTH must be a power of two in 256..4096");
   end
   localparam int AW = $clog2(MEM_DEPTH);

   // ========================================================================
   // state
   bbx_pkg::bbx_state_t state_reg;
   logic [1:0] phase_reg;
   logic [15:0] instr_reg;
   logic next_two_reg;
   logic [7:0] acc_reg;
   logic [4:0] status_reg;
   logic [3:0] bank_reg;
   logic [20:0] pc_reg;
   logic [7:0] mem_reg [MEM_DEPTH];
   logic [AW-1:0] maddr_reg;
   logic [AW-1:0] ea_reg;
   logic [7:0] opnd_reg;
   logic [7:0] res_reg;
   logic [4:0] flags_res_reg;
   logic wr_acc_reg;
   logic wr_file_reg;
   logic wr_pc_reg;
   logic skip_reg;
   logic [20:0] pc_tgt_reg;

   bbx_dec_if dif ();
   bbx_decode u_dec (
      .d(dif.dec)
   );
   assign dif.word = instr_reg;

   // ========================================================================
   // apb decode
   logic acc_phase;
   logic wr_go;
   logic wr_ok;
   logic [AW-1:0] ea_next;
   assign acc_phase = psel && penable && clk_en;
   // a transfer flagged at setup never writes, even if the run ended meanwhile
   assign wr_ok = state_reg == bbx_pkg::BBX_ST_IDLE && !pslverr;
   assign wr_go = acc_phase && pwrite && paddr == `BBX_CTRL_OFS && pwdata[`BBX_CTRL_GO]
      && wr_ok;

   // effective address: access bank or bank pointer
   always_comb begin
      if (dif.bank_sel) begin
         ea_next = AW'({bank_reg, dif.file_addr});
      end else if (dif.file_addr[7]) begin
         ea_next = AW'({4'hf, dif.file_addr});
      end else begin
         ea_next = AW'({4'h0, dif.file_addr});
      end
   end

   // ========================================================================
   // sequencer
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_reg <= bbx_pkg::BBX_ST_IDLE;
         phase_reg <= 2'h0;
         busy <= 1'b0;
      end else if (clk_en) begin
         case (state_reg)
            bbx_pkg::BBX_ST_IDLE: begin
               if (wr_go) begin
                  state_reg <= bbx_pkg::BBX_ST_EXEC;
                  phase_reg <= 2'h0;
                  busy <= 1'b1;
               end
            end
            bbx_pkg::BBX_ST_EXEC: begin
               phase_reg <= phase_reg + 2'h1;
               if (phase_reg == 2'(`BBX_PHASES - 1)) begin
                  if (wr_pc_reg || skip_reg) begin
                     state_reg <= bbx_pkg::BBX_ST_NOP1;
                  end else begin
                     state_reg <= bbx_pkg::BBX_ST_IDLE;
                     busy <= 1'b0;
                  end
               end
            end
            bbx_pkg::BBX_ST_NOP1: begin
               phase_reg <= phase_reg + 2'h1;
               if (phase_reg == 2'(`BBX_PHASES - 1)) begin
                  if (skip_reg && next_two_reg) begin
                     state_reg <= bbx_pkg::BBX_ST_NOP2;
                  end else begin
                     state_reg <= bbx_pkg::BBX_ST_IDLE;
                     busy <= 1'b0;
                  end
               end
            end
            bbx_pkg::BBX_ST_NOP2: begin
               phase_reg <= phase_reg + 2'h1;
               if (phase_reg == 2'(`BBX_PHASES - 1)) begin
                  state_reg <= bbx_pkg::BBX_ST_IDLE;
                  busy <= 1'b0;
               end
            end
            default: begin
               state_reg <= bbx_pkg::BBX_ST_IDLE;
               busy <= 1'b0;
            end
         endcase
      end
   end

   // ========================================================================
   // datapath, one phase per quarter cycle
   logic [8:0] sum9;
   logic [4:0] nib5;
   logic [7:0] bit_mask;
   assign sum9 = {1'b0, acc_reg} + {1'b0, opnd_reg} + {8'h00, status_reg[`BBX_FLAG_C]};
   assign nib5 = {1'b0, acc_reg[3:0]} + {1'b0, opnd_reg[3:0]}
      + {4'h0, status_reg[`BBX_FLAG_C]};
   assign bit_mask = 8'h01 << dif.bit_idx;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ea_reg <= '0;
         opnd_reg <= 8'h00;
         res_reg <= 8'h00;
         flags_res_reg <= `BBX_STATUS_RST;
         wr_acc_reg <= 1'b0;
         wr_file_reg <= 1'b0;
         wr_pc_reg <= 1'b0;
         skip_reg <= 1'b0;
         pc_tgt_reg <= `BBX_PC_RST;
      end else if (clk_en && state_reg == bbx_pkg::BBX_ST_EXEC) begin
         case (phase_reg)
            2'h0: begin
               ea_reg <= ea_next;
               wr_acc_reg <= 1'b0;
               wr_file_reg <= 1'b0;
               wr_pc_reg <= 1'b0;
               skip_reg <= 1'b0;
               flags_res_reg <= status_reg;
            end
            2'h1: begin
               if (dif.op == bbx_pkg::BBX_OP_AND_LITERAL_ACC) begin
                  opnd_reg <= dif.literal;
               end else begin
                  opnd_reg <= mem_reg[ea_reg];
               end
            end
            2'h2: begin
               case (dif.op)
                  bbx_pkg::BBX_OP_ADD_ACC_FILE_CARRY: begin
                     res_reg <= sum9[7:0];
                     flags_res_reg[`BBX_FLAG_C] <= sum9[8];
                     flags_res_reg[`BBX_FLAG_DC] <= nib5[4];
                     flags_res_reg[`BBX_FLAG_Z] <= sum9[7:0] == 8'h00;
                     flags_res_reg[`BBX_FLAG_N] <= sum9[7];
                     flags_res_reg[`BBX_FLAG_OV] <= (acc_reg[7] == opnd_reg[7])
                        && (sum9[7] != acc_reg[7]);
                     wr_acc_reg <= !dif.dest_file;
                     wr_file_reg <= dif.dest_file;
                  end
                  bbx_pkg::BBX_OP_AND_LITERAL_ACC: begin
                     res_reg <= acc_reg & opnd_reg;
                     flags_res_reg[`BBX_FLAG_Z] <= (acc_reg & opnd_reg) == 8'h00;
                     flags_res_reg[`BBX_FLAG_N] <= acc_reg[7] & opnd_reg[7];
                     wr_acc_reg <= 1'b1;
                  end
                  bbx_pkg::BBX_OP_FILE_BIT_CLEAR: begin
                     res_reg <= opnd_reg & ~bit_mask;
                     wr_file_reg <= 1'b1;
                  end
                  bbx_pkg::BBX_OP_FILE_BIT_SET: begin
                     res_reg <= opnd_reg | bit_mask;
                     wr_file_reg <= 1'b1;
                  end
                  bbx_pkg::BBX_OP_BRANCH_IF_NEGATIVE: begin
                     pc_tgt_reg <= pc_reg + 21'h2 + {{12{dif.literal[7]}}, dif.literal, 1'b0};
                     wr_pc_reg <= status_reg[`BBX_FLAG_N];
                  end
                  bbx_pkg::BBX_OP_RELATIVE_BRANCH: begin
                     pc_tgt_reg <= pc_reg + 21'h2 + {{9{dif.offset[10]}}, dif.offset, 1'b0};
                     wr_pc_reg <= 1'b1;
                  end
                  bbx_pkg::BBX_OP_TEST_SKIP_IF_ZERO: begin
                     skip_reg <= (opnd_reg & bit_mask) == 8'h00;
                  end
                  bbx_pkg::BBX_OP_TEST_SKIP_IF_ONE: begin
                     skip_reg <= (opnd_reg & bit_mask) != 8'h00;
                  end
                  default: begin
                     res_reg <= opnd_reg;
                  end
               endcase
            end
            default: begin
            end
         endcase
      end
   end

   // ========================================================================
   // architectural state: write-back in phase four, or by software when idle
   logic wb;
   assign wb = clk_en && state_reg == bbx_pkg::BBX_ST_EXEC && phase_reg == 2'h3;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         acc_reg <= `BBX_ACC_RST;
         status_reg <= `BBX_STATUS_RST;
         bank_reg <= `BBX_BANK_RST;
         instr_reg <= 16'h0000;
         next_two_reg <= 1'b0;
         maddr_reg <= '0;
      end else if (wb) begin
         status_reg <= flags_res_reg;
         if (wr_acc_reg) begin
            acc_reg <= res_reg;
         end
      end else if (acc_phase && pwrite && wr_ok) begin
         case (paddr)
            `BBX_CTRL_OFS: next_two_reg <= pwdata[`BBX_CTRL_NEXT2];
            `BBX_INSTR_OFS: instr_reg <= pwdata[15:0];
            `BBX_ACC_OFS: acc_reg <= pwdata[7:0];
            `BBX_STATUS_OFS: status_reg <= pwdata[4:0];
            `BBX_BANK_OFS: bank_reg <= pwdata[3:0];
            `BBX_MADDR_OFS: maddr_reg <= pwdata[AW-1:0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pc_reg <= `BBX_PC_RST;
      end else if (wb) begin
         if (wr_pc_reg) begin
            pc_reg <= pc_tgt_reg;
         end else begin
            pc_reg <= pc_reg + 21'h2;
         end
      end else if (clk_en && state_reg != bbx_pkg::BBX_ST_IDLE && phase_reg == 2'h3
            && skip_reg) begin
         pc_reg <= pc_reg + 21'h2;
      end else if (acc_phase && pwrite && wr_ok && paddr == `BBX_PC_OFS) begin
         pc_reg <= pwdata[20:0];
      end
   end

   // data memory, one generate per entry
   for (genvar gi = 0; gi < MEM_DEPTH; gi++) begin : g_mem
      always_ff @(posedge clock) begin
         if (!rst_n) begin
            mem_reg[gi] <= 8'h00;
         end else if (wb && wr_file_reg && ea_reg == AW'(gi)) begin
            mem_reg[gi] <= res_reg;
         end else if (acc_phase && pwrite && wr_ok && paddr == `BBX_MEM_OFS
               && maddr_reg == AW'(gi)) begin
            mem_reg[gi] <= pwdata[7:0];
         end
      end
   end

   // ========================================================================
   // apb read and answer
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         pc_out <= `BBX_PC_RST;
      end else if (clk_en) begin
         pc_out <= pc_reg;
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            prdata <= 32'h00000000;
            case (paddr)
               `BBX_CTRL_OFS: prdata <= {30'h0, next_two_reg, 1'b0};
               `BBX_INSTR_OFS: prdata <= {16'h0, instr_reg};
               `BBX_ACC_OFS: prdata <= {24'h0, acc_reg};
               `BBX_STATUS_OFS: prdata <= {27'h0, status_reg};
               `BBX_BANK_OFS: prdata <= {28'h0, bank_reg};
               `BBX_PC_OFS: prdata <= {11'h0, pc_reg};
               `BBX_MEM_OFS: prdata <= {24'h0, mem_reg[maddr_reg]};
               `BBX_MADDR_OFS: prdata <= 32'(maddr_reg);
               `BBX_STATE_OFS: prdata <= {26'h0, phase_reg, 2'h0,
                  state_reg == bbx_pkg::BBX_ST_IDLE, busy};
               default: pslverr <= 1'b1;
            endcase
            if (pwrite && paddr != `BBX_STATE_OFS && state_reg != bbx_pkg::BBX_ST_IDLE) begin
               pslverr <= 1'b1;
            end
         end
      end
   end
endmodule

// File: bbx_regs.svh
// register map, field positions, reset values and timing counts for the execute unit
`ifndef BBX_REGS_SVH
`define BBX_REGS_SVH

// ==========================================================================
// apb register offsets (byte addresses)
`define BBX_CTRL_OFS 12'h000
`define BBX_INSTR_OFS 12'h004
`define BBX_ACC_OFS 12'h008
`define BBX_STATUS_OFS 12'h00c
`define BBX_BANK_OFS 12'h010
`define BBX_PC_OFS 12'h014
`define BBX_MEM_OFS 12'h018
`define BBX_MADDR_OFS 12'h01c
`define BBX_STATE_OFS 12'h020

// ==========================================================================
// status flag positions
`define BBX_FLAG_C 0
`define BBX_FLAG_DC 1
`define BBX_FLAG_Z 2
`define BBX_FLAG_OV 3
`define BBX_FLAG_N 4

// ==========================================================================
// control fields
`define BBX_CTRL_GO 0
`define BBX_CTRL_NEXT2 1

// ==========================================================================
// reset values and timing
`define BBX_ACC_RST 8'h00
`define BBX_STATUS_RST 5'h00
`define BBX_BANK_RST 4'h0
`define BBX_PC_RST 21'h000000
`define BBX_PHASES 4

`endif

// File: bbx_pkg.sv
// types shared by the execute unit files
package bbx_pkg;
   // =======================================================================
   // instruction classes
   typedef enum logic [3:0] {
      BBX_OP_NONE = 4'h0,
      BBX_OP_ADD_ACC_FILE_CARRY = 4'h1,
      BBX_OP_AND_LITERAL_ACC = 4'h2,
      BBX_OP_FILE_BIT_CLEAR = 4'h3,
      BBX_OP_FILE_BIT_SET = 4'h4,
      BBX_OP_BRANCH_IF_NEGATIVE = 4'h5,
      BBX_OP_RELATIVE_BRANCH = 4'h6,
      BBX_OP_TEST_SKIP_IF_ZERO = 4'h7,
      BBX_OP_TEST_SKIP_IF_ONE = 4'h8
   } bbx_op_t;

   // =======================================================================
   // execution states, one-hot
   typedef enum logic [3:0] {
      BBX_ST_IDLE = 4'b0001,
      BBX_ST_EXEC = 4'b0010,
      BBX_ST_NOP1 = 4'b0100,
      BBX_ST_NOP2 = 4'b1000
   } bbx_state_t;
endpackage

// File: bbx_dec_if.sv
// decoded instruction fields passed from decoder to executor
`timescale 1ns/10ps
interface bbx_dec_if;
   logic [15:0] word;
   bbx_pkg::bbx_op_t op;
   logic dest_file;
   logic bank_sel;
   logic [2:0] bit_idx;
   logic [7:0] file_addr;
   logic [7:0] literal;
   logic [10:0] offset;
   modport dec (input word, output op, output dest_file, output bank_sel,
      output bit_idx, output file_addr, output literal, output offset);
   modport exe (output word, input op, input dest_file, input bank_sel,
      input bit_idx, input file_addr, input literal, input offset);
endinterface

// File: bbx_decode.sv
// instruction word decoder
`timescale 1ns/10ps
module bbx_decode (
   bbx_dec_if.dec d
);
   // ========================================================================
   // field extraction
   always_comb begin
      d.dest_file = d.word[9];
      d.bank_sel = d.word[8];
      d.bit_idx = d.word[11:9];
      d.file_addr = d.word[7:0];
      d.literal = d.word[7:0];
      d.offset = d.word[10:0];
      if (d.word[15:10] == 6'b001000) begin
         d.op = bbx_pkg::BBX_OP_ADD_ACC_FILE_CARRY;
      end else if (d.word[15:8] == 8'b00001011) begin
         d.op = bbx_pkg::BBX_OP_AND_LITERAL_ACC;
      end else if (d.word[15:12] == 4'b1001) begin
         d.op = bbx_pkg::BBX_OP_FILE_BIT_CLEAR;
      end else if (d.word[15:12] == 4'b1000) begin
         d.op = bbx_pkg::BBX_OP_FILE_BIT_SET;
      end else if (d.word[15:8] == 8'b11100110) begin
         d.op = bbx_pkg::BBX_OP_BRANCH_IF_NEGATIVE;
      end else if (d.word[15:11] == 5'b11010) begin
         d.op = bbx_pkg::BBX_OP_RELATIVE_BRANCH;
      end else if (d.word[15:12] == 4'b1011) begin
         d.op = bbx_pkg::BBX_OP_TEST_SKIP_IF_ZERO;
      end else if (d.word[15:12] == 4'b1010) begin
         d.op = bbx_pkg::BBX_OP_TEST_SKIP_IF_ONE;
      end else begin
         d.op = bbx_pkg::BBX_OP_NONE;
      end
   end
endmodule

// File: bbx_exec_chk.sv
// concurrent checks on the execute unit ports
`timescale 1ns/10ps
`include "bbx_regs.svh"
module bbx_exec_chk (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic busy,
   input wire logic [20:0] pc_out
);
   logic [4:0] run_reg;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   // ==========================================================================
   // busy cycle counter
   always_ff @(posedge clock) begin
      if (!rst_n || !busy) begin
         run_reg <= 5'h00;
      end else if (clk_en) begin
         run_reg <= run_reg + 5'h01;
      end
   end
   // ==========================================================================
   // bus and start sequences
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_go;
      psel && penable && pready && pwrite && paddr == `BBX_CTRL_OFS && pwdata[`BBX_CTRL_GO]
         && !busy;
   endsequence
   chk_zero_wait: assert property (s_setup |=> pready)
      else $error("no ready after setup");
   chk_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   chk_busy_start: assert property (s_go |=> busy)
      else $error("go did not start");
   chk_min_len: assert property ($rose(busy) |-> busy[*4])
      else $error("cycle shorter than four phases");
   chk_max_len: assert property ($rose(busy) |-> ##[4:12] !busy)
      else $error("execution too long");
   chk_len_set: assert property ($fell(busy) |-> run_reg inside {5'h04, 5'h08, 5'h0c})
      else $error("execution length not whole cycles");
   chk_busy_refuse: assert property (psel && penable && pready && pwrite && busy
      && paddr != `BBX_STATE_OFS |-> pslverr)
      else $error("write while busy accepted");
   chk_unmapped_rd: assert property (pready && !pwrite && paddr > `BBX_STATE_OFS
      |-> pslverr && prdata == 32'h0)
      else $error("unmapped read not refused");
   chk_pc_hold: assert property ((!busy && !psel)[*2] |=> $stable(pc_out))
      else $error("pc moved while idle");
endmodule
bind bbx_exec bbx_exec_chk u_chk (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy), .pc_out(pc_out));

// File: bbx_fetch_mdl.sv
// program store feeding instruction words at the program counter
`timescale 1ns/10ps
module bbx_fetch_mdl (
   input wire logic [20:0] pc,
   output logic [15:0] word
);
   logic [15:0] prog [0:15];
   // word addressed, byte bit 0 ignored
   assign word = prog[pc[4:1]];
endmodule

// File: tb_top.sv
// self-checking bench for the execute unit
`timescale 1ns/10ps
`include "bbx_regs.svh"
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin \
   $display("wrong value %s exp %h got %h", nm, ex, gt); n_errors++; end end
module tb_top;
   typedef struct {logic rd; logic err; logic [31:0] data;} bbx_note_t;
   logic clock = 1'b0;
   logic rst_n, clk_en, psel, penable, pwrite, sk;
   logic [11:0] paddr, ad;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, busy;
   logic [20:0] pc_out;
   logic [15:0] word;
   logic [7:0] a8, f8, fa, r8;
   logic [4:0] st, h5;
   logic [3:0] bk;
   logic [8:0] s9;
   logic [10:0] n11;
   logic [2:0] b3;
   int n_errors = 0;
   int tests_run = 0;
   int run_len = 0;
   int exp_len;
   int i;
   bbx_note_t q_bus[$];
   int q_len[$];
   bbx_note_t nt;
   always #20 clock = ~clock;
   bbx_exec #(.MEM_DEPTH(4096)) u_dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy), .pc_out(pc_out));
   bbx_fetch_mdl u_mdl (.pc(pc_out), .word(word));
   // ==========================================================================
   // result monitor
   always @(posedge clock) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         nt = q_bus.pop_front();
         `CHK("pslverr", nt.err, pslverr)
         if (nt.rd) `CHK("prdata", nt.data, prdata)
      end
      if (busy === 1'b1 && clk_en) run_len++;
      else if (busy === 1'b0 && run_len > 0) begin
         exp_len = q_len.pop_front();
         `CHK("run length", exp_len, run_len)
         run_len = 0;
      end
   end
   // ==========================================================================
   // bus tasks
   task end_sim();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] ex, input logic err);
      int k;
      k = 0;
      q_bus.push_back('{~w, err, ex});
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         n_errors++;
         end_sim();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] ex);
      apb(1'b0, a, 32'h0, ex, 1'b0);
   endtask
   task automatic mem_wr(input logic [11:0] a, input logic [7:0] d);
      wr(`BBX_MADDR_OFS, {20'h0, a});
      wr(`BBX_MEM_OFS, {24'h0, d});
   endtask
   task automatic mem_rd(input logic [11:0] a, input logic [7:0] ex);
      wr(`BBX_MADDR_OFS, {20'h0, a});
      rd(`BBX_MEM_OFS, {24'h0, ex});
   endtask
   task automatic exec(input logic [15:0] w, input logic nx2, input int len, input logic poke);
      int k;
      k = 0;
      wr(`BBX_INSTR_OFS, {16'h0, w});
      q_len.push_back(len);
      wr(`BBX_CTRL_OFS, {30'h0, nx2, 1'b1});
      if (poke) apb(1'b1, `BBX_ACC_OFS, 32'h77, 32'h0, 1'b1);
      do begin
         @(posedge clock);
         k++;
      end while (busy !== 1'b0 && k < 40);
      if (k >= 40) begin
         n_errors++;
         end_sim();
      end
   endtask
   // ==========================================================================
   // scenarios
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      clk_en = 1'b1;
      void'($urandom(90206));
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      rd(`BBX_ACC_OFS, {24'h0, `BBX_ACC_RST});
      rd(`BBX_STATUS_OFS, {27'h0, `BBX_STATUS_RST});
      rd(`BBX_PC_OFS, {11'h0, `BBX_PC_RST});
      rd(`BBX_STATE_OFS, 32'h00000002);
      for (i = 0; i < 8; i++) begin
         a8 = 8'($urandom);
         f8 = 8'($urandom);
         fa = 8'($urandom);
         bk = 4'($urandom);
         st = 5'($urandom);
         ad = i[0] ? {bk, fa} : (fa[7] ? {4'hf, fa} : {4'h0, fa});
         wr(`BBX_ACC_OFS, {24'h0, a8});
         wr(`BBX_STATUS_OFS, {27'h0, st});
         wr(`BBX_BANK_OFS, {28'h0, bk});
         mem_wr(ad, f8);
         exec({6'h08, i[1], i[0], fa}, 1'b0, 4, 1'b0);
         s9 = a8 + f8 + st[0];
         h5 = a8[3:0] + f8[3:0] + st[0];
         rd(`BBX_ACC_OFS, {24'h0, i[1] ? a8 : s9[7:0]});
         mem_rd(ad, i[1] ? s9[7:0] : f8);
         r8 = {3'h0, s9[7], a8[7] == f8[7] && s9[7] != a8[7], s9[7:0] == 8'h0, h5[4], s9[8]};
         rd(`BBX_STATUS_OFS, {24'h0, r8});
      end
      for (i = 0; i < 4; i++) begin
         a8 = 8'($urandom);
         f8 = i[0] ? ~a8 : 8'($urandom);
         st = 5'($urandom);
         wr(`BBX_ACC_OFS, {24'h0, a8});
         wr(`BBX_STATUS_OFS, {27'h0, st});
         exec({8'h0b, f8}, 1'b0, 4, 1'b0);
         r8 = a8 & f8;
         rd(`BBX_ACC_OFS, {24'h0, r8});
         rd(`BBX_STATUS_OFS, {27'h0, r8[7], st[3], r8 == 8'h0, st[1:0]});
      end
      for (i = 0; i < 8; i++) begin
         f8 = 8'($urandom);
         fa = 8'($urandom) & 8'h7f;
         st = 5'($urandom);
         wr(`BBX_STATUS_OFS, {27'h0, st});
         mem_wr({4'h0, fa}, f8);
         exec({4'h8, i[2:0], 1'b0, fa}, 1'b0, 4, 1'b0);
         exec({4'h9, ~i[2:0], 1'b0, fa}, 1'b0, 4, 1'b0);
         r8 = (f8 | (8'h01 << i[2:0])) & ~(8'h80 >> i[2:0]);
         mem_rd({4'h0, fa}, r8);
         rd(`BBX_STATUS_OFS, {27'h0, st});
      end
      for (i = 0; i < 3; i++) begin
         f8 = (i == 2) ? 8'h7f : 8'h80;
         wr(`BBX_STATUS_OFS, {27'h0, i != 1, 4'h0});
         wr(`BBX_PC_OFS, 32'h100);
         exec({8'he6, f8}, 1'b0, (i == 1) ? 4 : 8, 1'b0);
         rd(`BBX_PC_OFS, (i == 1) ? 32'h102 : 32'h102 + {{23{f8[7]}}, f8, 1'b0});
      end
      for (i = 0; i < 2; i++) begin
         n11 = i[0] ? 11'h3ff : 11'h400;
         wr(`BBX_ACC_OFS, 32'h11);
         wr(`BBX_PC_OFS, 32'h1000);
         exec({5'h1a, n11}, 1'b0, 8, i == 0);
         rd(`BBX_PC_OFS, 32'h1002 + {{20{n11[10]}}, n11, 1'b0});
         rd(`BBX_ACC_OFS, 32'h11);
      end
      for (i = 0; i < 8; i++) begin
         b3 = 3'($urandom);
         f8 = 8'($urandom);
         f8[b3] = i[1];
         st = 5'($urandom);
         sk = i[1] == i[0];
         mem_wr(12'h020, f8);
         wr(`BBX_STATUS_OFS, {27'h0, st});
         wr(`BBX_PC_OFS, 32'h0);
         exec({3'h5, ~i[0], b3, 1'b0, 8'h20}, i[2], sk ? (i[2] ? 12 : 8) : 4, 1'b0);
         rd(`BBX_PC_OFS, sk ? (i[2] ? 32'h6 : 32'h4) : 32'h2);
         mem_rd(12'h020, f8);
         rd(`BBX_STATUS_OFS, {27'h0, st});
      end
      u_mdl.prog[0] = 16'ha020;
      u_mdl.prog[1] = 16'h0b00;
      u_mdl.prog[2] = 16'h0b0f;
      mem_wr(12'h020, 8'h01);
      wr(`BBX_ACC_OFS, 32'hff);
      wr(`BBX_PC_OFS, 32'h0);
      repeat (2) @(posedge clock);
      exec(word, 1'b0, 8, 1'b0);
      @(posedge clock);
      exec(word, 1'b0, 4, 1'b0);
      clk_en <= 1'b0;
      repeat (3) @(posedge clock);
      clk_en <= 1'b1;
      rd(`BBX_ACC_OFS, 32'h0f);
      apb(1'b0, 12'h024, 32'h0, 32'h0, 1'b1);
      apb(1'b1, 12'h028, 32'h5, 32'h0, 1'b1);
      repeat (3) @(posedge clock);
      end_sim();
   end
   initial begin
      repeat (60000) @(posedge clock);
      n_errors++;
      end_sim();
   end
endmodule
